/* pkg/ppm_cfg.svh */
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

// Byte addresses of the four registers
`define PPM_OFF_PA      8'h00
`define PPM_OFF_PB      8'h04
`define PPM_OFF_PC      8'h08
`define PPM_OFF_CTL     8'h0c
`define PPM_ADDR_W      8

// Control word after chip reset: basic mode, every port input
`define PPM_CTL_RESET   8'h9b

// Control word fields
`define PPM_CTL_SEL     7
`define PPM_A_MODE_HI   6
`define PPM_A_MODE_LO   5
`define PPM_A_DIR       4
`define PPM_CU_DIR      3
`define PPM_B_MODE      2
`define PPM_B_DIR       1
`define PPM_CL_DIR      0

// Port C pin roles in strobed mode
`define PPM_PC_A_OBF    7
`define PPM_PC_A_ACK    6
`define PPM_PC_A_IBF    5
`define PPM_PC_A_STB    4
`define PPM_PC_A_IRQ    3
`define PPM_PC_B_HS     2
`define PPM_PC_B_FULL   1
`define PPM_PC_B_IRQ    0

// Bus responses
`define PPM_RESP_OKAY   2'b00
`define PPM_RESP_SLVERR 2'b10

`endif

/* pkg/ppm_pkg.sv */
`include "ppm_cfg.svh"

package ppm_pkg;

    // Group A operating mode
    typedef enum logic [1:0] {MODE_BASIC, MODE_STROBED, MODE_BIDIR} ppm_mode_e;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic                    awvalid;
        logic [`PPM_ADDR_W-1:0]  awaddr;
        logic                    wvalid;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    bready;
        logic                    arvalid;
        logic [`PPM_ADDR_W-1:0]  araddr;
        logic                    rready;
    } ppm_axi_req_s;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ppm_axi_rsp_s;

    // One 8-bit pin group, enable low while driven
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oeN;
    } ppm_pin_s;

    // Data latches and handshake flags of one group
    typedef struct packed {
        logic [7:0] outLat;
        logic [7:0] inLat;
        logic       ibf;
        logic       obfN;
        logic       intr;
    } ppm_grp_s;

    // Whole state of the port block
    typedef struct packed {
        logic [7:0]             ctl;
        ppm_grp_s               grpA;
        ppm_grp_s               grpB;
        logic [7:0]             latC;
        logic                   groupAOutputIrqEnable;
        logic                   groupAInputIrqEnable;
        logic                   groupBIrqEnable;
        logic [2:0]             syncMeta;
        logic [2:0]             syncHs;
        logic [2:0]             syncPrev;
        logic [7:0]             dA1;
        logic [7:0]             dA2;
        logic [7:0]             dB1;
        logic [7:0]             dB2;
        logic                   awHave;
        logic [`PPM_ADDR_W-1:0] awAddr;
        logic                   wHave;
        logic [31:0]            wData;
        logic [3:0]             wStrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } ppm_state_s;

endpackage : ppm_pkg

/* verilog/ppm_port.sv */
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`include "ppm_cfg.svh"

module ppm_port
    import ppm_pkg::*;
(
    input  wire logic         clk,     // 250 MHz system clock
    input  wire logic         rst,     // Asynchronous reset, active high
    input  wire ppm_axi_req_s axiReq,  // Register bus request
    output      ppm_axi_rsp_s axiRsp,  // Register bus answer
    input  wire logic [7:0]   paIn,    // Port A pin levels
    input  wire logic [7:0]   pbIn,    // Port B pin levels
    input  wire logic [7:0]   pcIn,    // Port C pin levels
    output      ppm_pin_s     paPin,   // Port A drive
    output      ppm_pin_s     pbPin,   // Port B drive
    output      ppm_pin_s     pcPin    // Port C drive
);

    ////////////////////////////////////////////////////////////////////////////////////
    ppm_state_s             st_r;
    ppm_state_s             st_nxt;
    ppm_mode_e              aMode;
    logic                   aIn;
    logic                   bIn;
    logic                   bStrobed;
    logic                   awFire;
    logic                   wFire;
    logic                   wrEn;
    logic [`PPM_ADDR_W-1:0] wrAddr;
    logic [31:0]            wrData;
    logic [3:0]             wrStrb;
    logic                   wrLane;
    logic                   wrA;
    logic                   wrB;
    logic                   wrC;
    logic                   wrCtl;
    logic                   rdEn;
    logic                   rdA;
    logic                   rdB;
    logic                   hsA;
    logic                   hsAPrev;
    logic                   inteA;
    logic [2:0]             bsrBit;
    logic [7:0]             pcVal;
    logic [7:0]             pcDrv;
    logic                   paDrv;
    logic                   pbDrv;
    logic [7:0]             rdByte;

    // Only four aligned words answer; the rest give a slave error
    function automatic logic is_mapped(input logic [`PPM_ADDR_W-1:0] addr);
        return addr == `PPM_OFF_PA || addr == `PPM_OFF_PB ||
               addr == `PPM_OFF_PC || addr == `PPM_OFF_CTL;
    endfunction : is_mapped

    // One group's handshake; a strobe fall setting input-full wins over a host read, other host clears win
    function automatic ppm_grp_s grp_step(
        input ppm_grp_s   g,
        input logic       strobed,
        input logic       dirIn,
        input logic       hs,
        input logic       hsPrev,
        input logic       inte,
        input logic       rd,
        input logic       wr,
        input logic [7:0] wd,
        input logic [7:0] pinData
    );
        ppm_grp_s n;
        n = g;
        if (wr) begin
            n.outLat = wd;
        end
        if (strobed && dirIn) begin
            if (!hs) begin
                n.inLat = pinData;
            end
            n.ibf  = (hsPrev && !hs) || (g.ibf && !rd);
            n.intr = (hs && n.ibf && inte) || (g.intr && !rd);
        end else if (strobed) begin
            // Host write wins over a held acknowledge so new data is not lost
            n.obfN = wr ? 1'b0 : (!hs ? 1'b1 : g.obfN);
            n.intr = (hs && n.obfN && inte) || (g.intr && !wr);
        end
        return n;
    endfunction : grp_step

    ////////////////////////////////////////////////////////////////////////////////////
    // Mode and direction decode from the control word
    assign aMode    = st_r.ctl[`PPM_A_MODE_HI] ? MODE_BIDIR :
                      (st_r.ctl[`PPM_A_MODE_LO] ? MODE_STROBED : MODE_BASIC);
    assign bStrobed = st_r.ctl[`PPM_B_MODE];
    assign aIn      = st_r.ctl[`PPM_A_DIR];
    assign bIn      = st_r.ctl[`PPM_B_DIR];

    // Group A uses strobe or acknowledge pin depending on direction
    assign hsA     = aIn ? st_r.syncHs[1] : st_r.syncHs[2];
    assign hsAPrev = aIn ? st_r.syncPrev[1] : st_r.syncPrev[2];
    assign inteA   = aIn ? st_r.groupAInputIrqEnable : st_r.groupAOutputIrqEnable;

    ////////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order, one at a time
    assign awFire = axiReq.awvalid && !st_r.awHave && !st_r.bvalid;
    assign wFire  = axiReq.wvalid && !st_r.wHave && !st_r.bvalid;
    assign wrAddr = st_r.awHave ? st_r.awAddr : axiReq.awaddr;
    assign wrData = st_r.wHave ? st_r.wData : axiReq.wdata;
    assign wrStrb = st_r.wHave ? st_r.wStrb : axiReq.wstrb;
    assign wrEn   = !st_r.bvalid && (st_r.awHave || awFire) && (st_r.wHave || wFire);
    // Registers are one byte wide, so only lane 0 stores
    assign wrLane = wrEn && wrStrb[0];
    assign wrA    = wrLane && wrAddr == `PPM_OFF_PA;
    assign wrB    = wrLane && wrAddr == `PPM_OFF_PB;
    assign wrC    = wrLane && wrAddr == `PPM_OFF_PC;
    assign wrCtl  = wrLane && wrAddr == `PPM_OFF_CTL;
    assign bsrBit = wrData[3:1];

    // Read channel: one read under way, answered the next cycle
    assign rdEn = axiReq.arvalid && !st_r.rvalid;
    assign rdA  = rdEn && axiReq.araddr == `PPM_OFF_PA;
    assign rdB  = rdEn && axiReq.araddr == `PPM_OFF_PB;

    ////////////////////////////////////////////////////////////////////////////////////
    // Pin drive and read-back mux
    always_comb begin
        pcVal = st_r.latC;
        pcDrv = {{4{!st_r.ctl[`PPM_CU_DIR]}}, {4{!st_r.ctl[`PPM_CL_DIR]}}};
        paDrv = 1'b0;
        unique case (aMode)
            MODE_BASIC: begin
                paDrv = !aIn;
            end
            MODE_STROBED: begin
                paDrv = !aIn;
                pcVal[`PPM_PC_A_IRQ] = st_r.grpA.intr;
                pcDrv[`PPM_PC_A_IRQ] = 1'b1;
                if (aIn) begin
                    pcVal[`PPM_PC_A_IBF] = st_r.grpA.ibf;
                    pcDrv[`PPM_PC_A_IBF] = 1'b1;
                    pcDrv[`PPM_PC_A_STB] = 1'b0;
                end else begin
                    pcVal[`PPM_PC_A_OBF] = st_r.grpA.obfN;
                    pcDrv[`PPM_PC_A_OBF] = 1'b1;
                    pcDrv[`PPM_PC_A_ACK] = 1'b0;
                end
            end
            MODE_BIDIR: begin
                paDrv = 1'b0;
            end
        endcase
        pbDrv = !bIn;
        if (bStrobed) begin
            // Low direction bit has no say once group B handshakes
            pcVal[`PPM_PC_B_IRQ]  = st_r.grpB.intr;
            pcVal[`PPM_PC_B_FULL] = bIn ? st_r.grpB.ibf : st_r.grpB.obfN;
            pcDrv[`PPM_PC_B_IRQ]  = 1'b1;
            pcDrv[`PPM_PC_B_FULL] = 1'b1;
            pcDrv[`PPM_PC_B_HS]   = 1'b0;
            if (aMode != MODE_STROBED) begin
                pcDrv[`PPM_PC_A_IRQ] = 1'b0;
            end
        end
        unique case (axiReq.araddr)
            `PPM_OFF_PA: begin
                rdByte = (aMode == MODE_STROBED && aIn) ? st_r.grpA.inLat :
                         (paDrv ? st_r.grpA.outLat : paIn);
            end
            `PPM_OFF_PB: begin
                rdByte = (bStrobed && bIn) ? st_r.grpB.inLat :
                         (pbDrv ? st_r.grpB.outLat : pbIn);
            end
            `PPM_OFF_PC: begin
                rdByte = (pcVal & pcDrv) | (pcIn & ~pcDrv);
            end
            `PPM_OFF_CTL: begin
                rdByte = st_r.ctl;
            end
            default: begin
                rdByte = 8'h00;
            end
        endcase
    end

    assign paPin.out = st_r.grpA.outLat;
    assign paPin.oeN = {8{!paDrv}};
    assign pbPin.out = st_r.grpB.outLat;
    assign pbPin.oeN = {8{!pbDrv}};
    assign pcPin.out = pcVal;
    assign pcPin.oeN = ~pcDrv;

    assign axiRsp.awready = !st_r.awHave && !st_r.bvalid;
    assign axiRsp.wready  = !st_r.wHave && !st_r.bvalid;
    assign axiRsp.bvalid  = st_r.bvalid;
    assign axiRsp.bresp   = st_r.bresp;
    assign axiRsp.arready = !st_r.rvalid;
    assign axiRsp.rvalid  = st_r.rvalid;
    assign axiRsp.rdata   = st_r.rdata;
    assign axiRsp.rresp   = st_r.rresp;

    ////////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Handshake pins and data pipelined alike so the capture lines up
        st_nxt.syncMeta = {pcIn[`PPM_PC_A_ACK], pcIn[`PPM_PC_A_STB], pcIn[`PPM_PC_B_HS]};
        st_nxt.syncHs   = st_r.syncMeta;
        st_nxt.syncPrev = st_r.syncHs;
        st_nxt.dA1      = paIn;
        st_nxt.dA2      = st_r.dA1;
        st_nxt.dB1      = pbIn;
        st_nxt.dB2      = st_r.dB1;
        st_nxt.grpA = grp_step(st_r.grpA, aMode == MODE_STROBED, aIn, hsA, hsAPrev,
                               inteA, rdA, wrA, wrData[7:0], st_r.dA2);
        st_nxt.grpB = grp_step(st_r.grpB, bStrobed, bIn, st_r.syncHs[0], st_r.syncPrev[0],
                               st_r.groupBIrqEnable, rdB, wrB, wrData[7:0], st_r.dB2);
        if (wrC) begin
            st_nxt.latC = wrData[7:0];
        end
        if (wrCtl && wrData[`PPM_CTL_SEL]) begin
            // Any mode write restarts the port from a clean state
            st_nxt.ctl    = wrData[7:0];
            st_nxt.grpA   = '0;
            st_nxt.grpB   = '0;
            // Output-full is active low: a cleared buffer reads high
            st_nxt.grpA.obfN = 1'b1;
            st_nxt.grpB.obfN = 1'b1;
            st_nxt.latC   = 8'h00;
            st_nxt.groupAOutputIrqEnable = 1'b0;
            st_nxt.groupAInputIrqEnable  = 1'b0;
            st_nxt.groupBIrqEnable       = 1'b0;
        end else if (wrCtl) begin
            st_nxt.latC[bsrBit] = wrData[0];
            if (aMode == MODE_STROBED && aIn && bsrBit == 3'(`PPM_PC_A_STB)) begin
                st_nxt.groupAInputIrqEnable = wrData[0];
            end
            if (aMode == MODE_STROBED && !aIn && bsrBit == 3'(`PPM_PC_A_ACK)) begin
                st_nxt.groupAOutputIrqEnable = wrData[0];
            end
            if (bStrobed && bsrBit == 3'(`PPM_PC_B_HS)) begin
                st_nxt.groupBIrqEnable = wrData[0];
            end
        end
        // Bus bookkeeping
        if (awFire) begin
            st_nxt.awHave = 1'b1;
            st_nxt.awAddr = axiReq.awaddr;
        end
        if (wFire) begin
            st_nxt.wHave = 1'b1;
            st_nxt.wData = axiReq.wdata;
            st_nxt.wStrb = axiReq.wstrb;
        end
        if (wrEn) begin
            st_nxt.awHave = 1'b0;
            st_nxt.wHave  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = is_mapped(wrAddr) ? `PPM_RESP_OKAY : `PPM_RESP_SLVERR;
        end else if (st_r.bvalid && axiReq.bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (rdEn) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = {24'h000000, rdByte};
            st_nxt.rresp  = is_mapped(axiReq.araddr) ? `PPM_RESP_OKAY : `PPM_RESP_SLVERR;
        end else if (st_r.rvalid && axiReq.rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    // State register; reset leaves every port an input in basic mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r     <= '0;
            st_r.ctl <= `PPM_CTL_RESET;
            st_r.grpA.obfN <= 1'b1;
            st_r.grpB.obfN <= 1'b1;
            st_r.syncMeta <= 3'h7;
            st_r.syncHs   <= 3'h7;
            st_r.syncPrev <= 3'h7;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_obf_on_write: assert property (
        wrA && aMode == MODE_STROBED && !aIn |=> !st_r.grpA.obfN
    ) else $error("output full not asserted after port write");

    a_ack_clears_obf: assert property (
        aMode == MODE_STROBED && !aIn && !st_r.syncHs[2] && !wrA && !wrCtl
        |=> st_r.grpA.obfN
    ) else $error("acknowledge did not clear output full");

    a_strobe_sets_ibf: assert property (
        bStrobed && bIn && st_r.syncPrev[0] && !st_r.syncHs[0] && !wrCtl
        |=> st_r.grpB.ibf ##1 st_r.grpB.ibf || $past(rdB)
    ) else $error("strobe fall did not set input full");

    a_read_clears_irq: assert property (
        rdB && bStrobed && bIn && !(st_r.syncPrev[0] && !st_r.syncHs[0])
        |=> !st_r.grpB.intr && !st_r.grpB.ibf
    ) else $error("input read did not clear request");

    a_irq_on_accept: assert property (
        aMode == MODE_STROBED && !aIn && st_r.groupAOutputIrqEnable && st_r.syncHs[2] &&
        st_r.grpA.obfN && !wrA && !wrCtl |=> st_r.grpA.intr ##0 pcPin.out[3]
    ) else $error("output request not raised");

    a_mode_clears: assert property (
        wrCtl && wrData[7] |=> st_r.grpA.outLat == 8'h00 && st_r.latC == 8'h00 &&
        !st_r.groupAOutputIrqEnable && !st_r.groupAInputIrqEnable && !st_r.groupBIrqEnable &&
        st_r.grpA.obfN && st_r.grpB.obfN
    ) else $error("mode write left state behind");

    a_bit_setreset: assert property (
        wrCtl && !wrData[7] |=> st_r.latC[$past(bsrBit)] == $past(wrData[0])
    ) else $error("single bit command missed");

    a_flow_through: assert property (
        rdA && aMode == MODE_BASIC && aIn |=> st_r.rvalid && st_r.rdata[7:0] == $past(paIn)
    ) else $error("basic input not flowing through");

    a_strobe_pins: assert property (
        aMode == MODE_STROBED |-> !pcPin.oeN[3] && pcPin.oeN[aIn ? 4 : 6]
    ) else $error("group A handshake pins misdirected");

    a_sync_delay: assert property (
        (!pcIn[4]) [*3] |=> !st_r.syncHs[1]
    ) else $error("strobe synchroniser delay wrong");

    c_input_transfer: cover property (st_r.grpA.ibf ##[1:50] rdA);
    c_output_ack:     cover property (!st_r.grpB.obfN ##[1:50] st_r.grpB.intr);
    c_bit_command:    cover property (wrCtl && !wrData[7] && bsrBit == 3'h4);

endmodule : ppm_port

/* tb/ppm_periph.sv */
////////////////////////////////////////////////////////////
// Far-side peripheral: data lines plus strobe and ack pins
module ppm_periph (
    input  wire logic       clk,   // System clock
    output      logic [7:0] paDrv, // Port A far-side drive
    output      logic [7:0] pbDrv, // Port B far-side drive
    output      logic [7:0] pcDrv  // Port C far-side drive
);
    timeunit 1ns;
    timeprecision 1ps;

    // Handshake lines idle high
    initial begin
        paDrv = 8'h00;
        pbDrv = 8'h00;
        pcDrv = 8'hff;
    end

    // One byte in; g high selects group B, low sets strobe width
    task automatic strobe(input logic g, input logic [7:0] d, input int low);
        @(posedge clk);
        if (g) begin
            pbDrv <= d;
        end else begin
            paDrv <= d;
        end
        pcDrv[g ? 2 : 4] <= 1'b0;
        repeat (low) @(posedge clk);
        pcDrv[g ? 2 : 4] <= 1'b1;
        // Held past the rising strobe, then scrambled so stale data shows
        repeat (2) @(posedge clk);
        if (g) begin
            pbDrv <= ~d;
        end else begin
            paDrv <= ~d;
        end
    endtask : strobe

    // Accept one output byte, prompt or slow
    task automatic ack(input logic g, input int low);
        @(posedge clk);
        pcDrv[g ? 2 : 6] <= 1'b0;
        repeat (low) @(posedge clk);
        pcDrv[g ? 2 : 6] <= 1'b1;
    endtask : ack
endmodule : ppm_periph

/* tb/ppm_port_tb_top.sv */
`include "ppm_cfg.svh"

module ppm_port_tb_top
    import ppm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk, rst;
    ppm_axi_req_s req;
    ppm_axi_rsp_s rsp;
    ppm_pin_s     paPin, pbPin, pcPin;
    logic [7:0]   paDrv, pbDrv, pcDrv, paLvl, pbLvl, pcLvl;
    logic [31:0]  rdData;
    logic [1:0]   rdResp, wrResp;
    int           fails, compares;

    // Wire level: device where enable low, peripheral elsewhere
    assign paLvl = (paPin.out & ~paPin.oeN) | (paDrv & paPin.oeN);
    assign pbLvl = (pbPin.out & ~pbPin.oeN) | (pbDrv & pbPin.oeN);
    assign pcLvl = (pcPin.out & ~pcPin.oeN) | (pcDrv & pcPin.oeN);

    ppm_port ppm_port_i (.clk(clk), .rst(rst), .axiReq(req), .axiRsp(rsp), .paIn(paLvl),
        .pbIn(pbLvl), .pcIn(pcLvl), .paPin(paPin), .pbPin(pbPin), .pcPin(pcPin));
    ppm_periph ppm_periph_i (.clk(clk), .paDrv(paDrv), .pbDrv(pbDrv), .pcDrv(pcDrv));

    ////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hang guard
    initial begin
        #400000;
        fails++;
        end_of_test();
    end

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    ////////////////////////////////////////////////////////////
    // Bus master; valids drop on the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        repeat (50) begin
            @(posedge clk);
            req.awvalid <= req.awvalid && !rsp.awready;
            req.wvalid  <= req.wvalid && !rsp.wready;
            if (rsp.bvalid) begin
                wrResp = rsp.bresp;
                req.bready <= 1'b0;
                return;
            end
        end
        chk(0, 1, "write timeout");
        end_of_test();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        repeat (50) begin
            @(posedge clk);
            req.arvalid <= req.arvalid && !rsp.arready;
            if (rsp.rvalid) begin
                rdData = rsp.rdata;
                rdResp = rsp.rresp;
                req.rready <= 1'b0;
                return;
            end
        end
        chk(0, 1, "read timeout");
        end_of_test();
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk({rdData, rdResp}, {24'h0, e, `PPM_RESP_OKAY}, "read data");
    endtask : rchk

    // Bounded wait for a port C output level
    task automatic waitPc(input int b, input logic v);
        repeat (20) begin
            @(negedge clk);
            if (pcPin.out[b] === v) begin
                compares++;
                return;
            end
        end
        chk(b, 99, "port C bit never settled");
        end_of_test();
    endtask : waitPc

    // Port C read: latch on driven halves, pins elsewhere
    function automatic logic [7:0] expC(input logic [7:0] c, input logic [7:0] lat,
                                        input logic [7:0] pin);
        logic [7:0] drv;
        drv = {{4{~c[3]}}, {4{~c[0]}}};
        return (lat & drv) | (pin & ~drv);
    endfunction : expC

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] c, da;
        logic [2:0] k;
        logic       v;
        req = '0;
        rst = 1'b1;
        void'($urandom(32'h52c8));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rchk(`PPM_OFF_CTL, `PPM_CTL_RESET);
        chk(paPin.oeN & pbPin.oeN & pcPin.oeN, 8'hff, "reset drive");
        // All sixteen basic direction mixes, random pins and data
        for (int i = 0; i < 16; i++) begin
            c = {3'b100, i[3:2], 1'b0, i[1:0]};
            k = 3'($urandom_range(7));
            v = 1'($urandom);
            da = 8'($urandom);
            ppm_periph_i.paDrv <= 8'($urandom);
            ppm_periph_i.pbDrv <= 8'($urandom);
            ppm_periph_i.pcDrv <= 8'($urandom);
            wr(`PPM_OFF_CTL, {24'h0, c});
            @(negedge clk);
            chk(paPin.out | pbPin.out, 8'h00, "latch cleared");
            chk({paPin.oeN, pbPin.oeN, pcPin.oeN}, {{8{c[4]}}, {8{c[1]}}, {4{c[3]}}, {4{c[0]}}},
                "directions");
            wr(`PPM_OFF_PA, {24'h0, da});
            wr(`PPM_OFF_PB, {24'h0, ~da});
            wr(`PPM_OFF_CTL, {28'h0, k, v});
            chk(wrResp, `PPM_RESP_OKAY, "write resp");
            chk(paLvl, c[4] ? paDrv : da, "port A pins");
            rchk(`PPM_OFF_PA, c[4] ? paDrv : da);
            rchk(`PPM_OFF_PB, c[1] ? pbDrv : ~da);
            rchk(`PPM_OFF_PC, expC(c, 8'(v) << k, pcDrv));
        end
        wr(8'h10, 32'h5a);
        chk(wrResp, `PPM_RESP_SLVERR, "unmapped write");
        rd(8'h10);
        chk({rdData, rdResp}, {32'h0, `PPM_RESP_SLVERR}, "unmapped read");
        // Strobed input both groups; enables on, then off
        ppm_periph_i.pcDrv <= 8'hff;
        wr(`PPM_OFF_CTL, 32'hb6);
        @(negedge clk);
        chk(pcPin.oeN, 8'h14, "input roles");
        wr(`PPM_OFF_CTL, 32'h09);
        wr(`PPM_OFF_CTL, 32'h05);
        for (int g = 0; g < 4; g++) begin
            if (g == 2) begin
                wr(`PPM_OFF_CTL, 32'h08);
                wr(`PPM_OFF_CTL, 32'h04);
            end
            da = 8'($urandom);
            ppm_periph_i.strobe(g[0], da, g[1] ? 1 : 5);
            waitPc(g[0] ? 1 : 5, 1'b1);
            repeat (6) @(negedge clk);
            chk(pcPin.out[g[0] ? 0 : 3], !g[1], "input irq");
            rchk(g[0] ? `PPM_OFF_PB : `PPM_OFF_PA, da);
            @(negedge clk);
            chk(pcPin.out[g[0] ? 1 : 5] | pcPin.out[g[0] ? 0 : 3], 0, "read clears");
        end
        // Strobed output; low port C direction set but ignored
        wr(`PPM_OFF_CTL, 32'ha5);
        @(negedge clk);
        chk(pcPin.oeN, 8'h44, "output roles");
        wr(`PPM_OFF_CTL, 32'h0d);
        wr(`PPM_OFF_CTL, 32'h05);
        for (int g = 0; g < 2; g++) begin
            da = 8'($urandom);
            wr(g ? `PPM_OFF_PB : `PPM_OFF_PA, {24'h0, da});
            @(negedge clk);
            chk(g ? pbPin.out : paPin.out, da, "output latch");
            chk(pcPin.out[g ? 1 : 7], 0, "output full");
            ppm_periph_i.ack(g[0], g ? 1 : 4);
            waitPc(g ? 1 : 7, 1'b1);
            waitPc(g ? 0 : 3, 1'b1);
            wr(g ? `PPM_OFF_PB : `PPM_OFF_PA, {24'h0, ~da});
            @(negedge clk);
            chk({pcPin.out[g ? 1 : 7], pcPin.out[g ? 0 : 3]}, 0, "write clears");
        end
        wr(`PPM_OFF_CTL, 32'hac);
        @(negedge clk);
        chk({paPin.out, pcPin.out[7], pcPin.out[3], pcPin.oeN[5:4]}, 12'h00b,
            "mode rewrite");
        wr(`PPM_OFF_CTL, 32'hc0);
        @(negedge clk);
        chk(paPin.oeN, 8'hff, "bidir idle");
        end_of_test();
    end
endmodule : ppm_port_tb_top
